// >>> core/rddp_pkg.sv
// rddp_pkg: shared constants and carriers for the receive ddr output.
// assumes one word carries pairs ab, cd and ef; pair index 0 is ab.
`default_nettype none

package rddp_pkg;

   // ----------------------------------------------------------------
   // widths and positions
   // ----------------------------------------------------------------
   localparam int RDDP_PAIRS = 3;
   localparam int RDDP_BUS_W = 10;
   localparam int RDDP_BYTE_W = 8;
   localparam int RDDP_PAIR_AB = 0;
   localparam int RDDP_PAIR_CD = 1;
   localparam int RDDP_PAIR_EF = 2;
   localparam int RDDP_BIT8 = 8;
   localparam int RDDP_BIT9 = 9;
   localparam int RDDP_KFLAG_BIT = 3;

   // ----------------------------------------------------------------
   // buffer and clock divider
   // ----------------------------------------------------------------
   localparam logic [1:0] RDDP_BUF_DEPTH = 2'h2;
   localparam logic [3:0] RDDP_DIV_RATIO = 4'ha;
   localparam logic [3:0] RDDP_DIV_HALF = 4'h5;
   localparam logic [3:0] RDDP_DIV_LAST = 4'h9;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [RDDP_BUS_W-1:0] data;   // raw word, or byte in [7:0]
      logic kFlag;                   // control character when decoded
   } rddp_chan_s;

   typedef struct packed {
      rddp_chan_s second;            // b, d, f
      rddp_chan_s first;             // a, c, e
   } rddp_pair_s;

   typedef struct packed {
      rddp_pair_s [RDDP_PAIRS-1:0] pair;
   } rddp_word_s;

   typedef logic [RDDP_BUS_W-1:0] rddp_bus_t;

endpackage

`default_nettype wire

// >>> core/rddp_rx_ddr_out.sv
// rddp_rx_ddr_out: receive double-data-rate parallel output, pairs cd, ef
// and bit 9 of pair ab. assumes words arrive on clock with valid/ready,
// mode pins are static while running, and the protocol device latches on
// both edges of rxByteClock.
`timescale 1ns/1ps
`default_nettype none

module rddp_rx_ddr_out
   import rddp_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire rddp_word_s inWord,
   input wire logic inValid,
   output logic inReady,
   input wire logic referenceClock,
   input wire logic recoveredClock,
   input wire logic nibbleMode,
   input wire logic decodeSelect,
   input wire logic clockToleranceComp,
   output logic rxByteClock,
   output logic [RDDP_BYTE_W-1:0] rxPairCdBusLow,
   output logic rxPairCdBit8Kflag,
   output logic rxPairCdBit9,
   output logic [RDDP_BYTE_W-1:0] rxPairEfBusLow,
   output logic rxPairEfBit8Kflag,
   output logic rxPairEfBit9,
   output logic rxPairAbBit9
);

   // ----------------------------------------------------------------
   // lane mapping
   // ----------------------------------------------------------------
   function automatic rddp_bus_t busMap(input rddp_pair_s p,
                                       input logic nib,
                                       input logic dec,
                                       input logic rise);
      rddp_chan_s ch;
      rddp_bus_t r;
      ch = rise ? p.second : p.first;
      if (!nib && !dec)
         r = ch.data;
      else if (!nib)
         r = {1'b0, ch.kFlag, ch.data[RDDP_BYTE_W-1:0]};
      else if (!dec && rise)
         r = {p.second.data[9:5], p.first.data[9:5]};
      else if (!dec)
         r = {p.second.data[4:0], p.first.data[4:0]};
      else if (rise)
         // flag sits in slot bit 3; msb of the nibble moves to slot bit 4
         r = {p.second.data[7], p.second.kFlag, p.second.data[6:4],
              p.first.data[7], p.first.kFlag, p.first.data[6:4]};
      else
         r = {1'b0, p.second.data[3:0], 1'b0, p.first.data[3:0]};
      return r;
   endfunction

   // ----------------------------------------------------------------
   // byte clock generation
   // ----------------------------------------------------------------
   logic [3:0] divCnt_q, divCnt_d;
   logic divClk_q, divClk_d, byteClk;

   always_comb
   begin
      divCnt_d = (divCnt_q == RDDP_DIV_LAST) ? 4'h0 : divCnt_q + 4'h1;
      divClk_d = divClk_q;
      if (divCnt_q == RDDP_DIV_LAST || divCnt_q == RDDP_DIV_HALF - 4'h1)
         divClk_d = ~divClk_q;
   end

   always_ff @(posedge recoveredClock or negedge resetn)
   begin
      if (!resetn)
      begin
         divCnt_q <= 4'h0;
         divClk_q <= 1'b0;
      end
      else
      begin
         divCnt_q <= divCnt_d;
         divClk_q <= divClk_d;
      end
   end

   // select is taken from the pins directly: the mux cannot be retimed by
   // the clock it picks, so the modes must only change while idle
   assign byteClk = (clockToleranceComp || !nibbleMode) ?
                    referenceClock : divClk_q;
   assign rxByteClock = byteClk;

   // ----------------------------------------------------------------
   // two-entry buffer on clock
   // ----------------------------------------------------------------
   rddp_word_s buf0_q, buf0_d, buf1_q, buf1_d;
   logic [1:0] cnt_q, cnt_d;
   rddp_word_s xfer_q, xfer_d;
   logic req_q, req_d;
   logic ackSync1_q, ackSync2_q, ack_q;
   logic push, pop, sendIdle;

   assign inReady = (cnt_q != RDDP_BUF_DEPTH);
   assign push = inValid && inReady;
   // the handshake stalls the buffer until the link side has taken a word
   assign sendIdle = (req_q == ackSync2_q);
   assign pop = sendIdle && (cnt_q != 2'h0);

   always_comb
   begin
      buf0_d = buf0_q;
      buf1_d = buf1_q;
      cnt_d = cnt_q;
      xfer_d = xfer_q;
      req_d = req_q;
      if (pop)
      begin
         xfer_d = buf0_q;
         req_d = ~req_q;
         buf0_d = buf1_q;
      end
      if (push)
      begin
         if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
            buf0_d = inWord;
         else
            buf1_d = inWord;
      end
      if (push && !pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'h1;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         buf0_q <= '0;
         buf1_q <= '0;
         cnt_q <= 2'h0;
         xfer_q <= '0;
         req_q <= 1'b0;
         ackSync1_q <= 1'b0;
         ackSync2_q <= 1'b0;
      end
      else
      begin
         buf0_q <= buf0_d;
         buf1_q <= buf1_d;
         cnt_q <= cnt_d;
         xfer_q <= xfer_d;
         req_q <= req_d;
         ackSync1_q <= ack_q;
         ackSync2_q <= ackSync1_q;
      end
   end

   // ----------------------------------------------------------------
   // link side on the byte clock
   // ----------------------------------------------------------------
   logic reqSync1_q, reqSync2_q, ack_d;
   logic [1:0] modeSync1_q, modeSync2_q;
   logic nibS, decS;
   rddp_word_s cur_q, cur_d;
   rddp_bus_t rise_q [RDDP_PAIRS], rise_d [RDDP_PAIRS];
   rddp_bus_t fall_q [RDDP_PAIRS], fall_d [RDDP_PAIRS];
   rddp_bus_t busOut [RDDP_PAIRS];

   assign nibS = modeSync2_q[0];
   assign decS = modeSync2_q[1];

   always_comb
   begin
      // no word waiting: the bus idles at zero rather than repeating data
      cur_d = '0;
      ack_d = ack_q;
      if (reqSync2_q != ack_q)
      begin
         cur_d = xfer_q;
         ack_d = reqSync2_q;
      end
      for (int p = 0; p < RDDP_PAIRS; p++)
      begin
         rise_d[p] = busMap(cur_q.pair[p], nibS, decS, 1'b1);
         fall_d[p] = busMap(cur_q.pair[p], nibS, decS, 1'b0);
      end
   end

   always_ff @(posedge byteClk or negedge resetn)
   begin
      if (!resetn)
      begin
         reqSync1_q <= 1'b0;
         reqSync2_q <= 1'b0;
         ack_q <= 1'b0;
         modeSync1_q <= 2'h0;
         modeSync2_q <= 2'h0;
         cur_q <= '0;
         for (int p = 0; p < RDDP_PAIRS; p++)
            rise_q[p] <= '0;
      end
      else
      begin
         reqSync1_q <= req_q;
         reqSync2_q <= reqSync1_q;
         ack_q <= ack_d;
         modeSync1_q <= {decodeSelect, nibbleMode};
         modeSync2_q <= modeSync1_q;
         cur_q <= cur_d;
         for (int p = 0; p < RDDP_PAIRS; p++)
            rise_q[p] <= rise_d[p];
      end
   end

   // falling half of each word goes out before its rising half
   always_ff @(negedge byteClk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int p = 0; p < RDDP_PAIRS; p++)
            fall_q[p] <= '0;
      end
      else
      begin
         for (int p = 0; p < RDDP_PAIRS; p++)
            fall_q[p] <= fall_d[p];
      end
   end

   // ----------------------------------------------------------------
   // ddr output select
   // ----------------------------------------------------------------
   generate
      for (genvar p = 0; p < RDDP_PAIRS; p++)
      begin : gDdr
         assign busOut[p] = byteClk ? rise_q[p] : fall_q[p];
      end
   endgenerate

   assign rxPairCdBusLow = busOut[RDDP_PAIR_CD][RDDP_BYTE_W-1:0];
   assign rxPairCdBit8Kflag = busOut[RDDP_PAIR_CD][RDDP_BIT8];
   assign rxPairCdBit9 = busOut[RDDP_PAIR_CD][RDDP_BIT9];
   assign rxPairEfBusLow = busOut[RDDP_PAIR_EF][RDDP_BYTE_W-1:0];
   assign rxPairEfBit8Kflag = busOut[RDDP_PAIR_EF][RDDP_BIT8];
   assign rxPairEfBit9 = busOut[RDDP_PAIR_EF][RDDP_BIT9];
   assign rxPairAbBit9 = busOut[RDDP_PAIR_AB][RDDP_BIT9];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_mux_rise_second: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (!nibS && !decS) |=>
         rise_q[RDDP_PAIR_CD] == $past(cur_q.pair[RDDP_PAIR_CD].second.data))
      else $error("mux raw rising edge does not carry second channel");

   chk_mux_fall_first: assert property (
      @(negedge byteClk) disable iff (!resetn)
      (!nibS && !decS) |=>
         fall_q[RDDP_PAIR_EF] == $past(cur_q.pair[RDDP_PAIR_EF].first.data))
      else $error("mux raw falling edge does not carry first channel");

   chk_mux_kflag_bit: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (!nibS && decS) |=>
         rise_q[RDDP_PAIR_CD][RDDP_BIT8] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.kFlag) &&
         !rise_q[RDDP_PAIR_CD][RDDP_BIT9])
      else $error("mux decoded bit 8 is not the control flag");

   chk_nib_low_fall: assert property (
      @(negedge byteClk) disable iff (!resetn)
      (nibS && !decS) |=>
         fall_q[RDDP_PAIR_CD][4:0] ==
            $past(cur_q.pair[RDDP_PAIR_CD].first.data[4:0]))
      else $error("nibble low half not on falling edge");

   chk_nib_high_rise: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (nibS && !decS) |=>
         rise_q[RDDP_PAIR_CD][9:5] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.data[9:5]))
      else $error("nibble second channel not on upper bus bits");

   chk_nib_first_flag: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (nibS && decS) |=>
         rise_q[RDDP_PAIR_EF][RDDP_KFLAG_BIT] ==
            $past(cur_q.pair[RDDP_PAIR_EF].first.kFlag))
      else $error("nibble bit 3 is not the first channel flag");

   chk_nib_raw_top: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (nibS && !decS) |=>
         rise_q[RDDP_PAIR_CD][RDDP_BIT8] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.data[RDDP_BIT8]) &&
         rise_q[RDDP_PAIR_CD][RDDP_BIT9] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.data[RDDP_BIT9]))
      else $error("nibble raw bits 8 and 9 misplaced");

   chk_nib_dec_bit8: assert property (
      @(negedge byteClk) disable iff (!resetn)
      (nibS && decS) |=>
         fall_q[RDDP_PAIR_CD][RDDP_BIT8] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.data[3]))
      else $error("nibble decoded bit 8 is not data bit 3 on falling edge");

   chk_nib_byte_flag: assert property (
      @(posedge byteClk) disable iff (!resetn)
      (nibS && decS) |=>
         rise_q[RDDP_PAIR_CD][RDDP_BIT8] ==
            $past(cur_q.pair[RDDP_PAIR_CD].second.kFlag))
      else $error("nibble second channel flag missing on rising edge");

   chk_div_wrap: assert property (
      @(posedge recoveredClock) disable iff (!resetn)
      (divCnt_q == RDDP_DIV_LAST) |=>
         (divCnt_q == 4'h0) && $changed(divClk_q))
      else $error("recovered clock divider does not wrap at ten");

endmodule

`default_nettype wire

// >>> dv/rddp_proto_model.sv
// rddp_proto_model: protocol device that latches the receive ddr buses.
// assumes the bus settles within 2 ns of each byte clock edge.
`timescale 1ns/1ps
`default_nettype none

module rddp_proto_model
   import rddp_pkg::*;
(
   input wire logic rxByteClock,
   input wire logic [RDDP_BUS_W-1:0] cdBus,
   input wire logic [RDDP_BUS_W-1:0] efBus,
   input wire logic abBit9
);
   // ----------------------------------------------------------------
   // capture, falling half first then rising half
   // ----------------------------------------------------------------
   logic [20:0] fallHalf;
   logic [41:0] got[$];

   // sample 2 ns after the edge, not on it, so the ddr mux has switched
   always @(negedge rxByteClock)
   begin
      #2;
      fallHalf = {abBit9, efBus, cdBus};
   end

   // idle periods carry zeros; only words are queued
   always @(posedge rxByteClock)
   begin
      #2;
      if ({abBit9, efBus, cdBus, fallHalf} !== 42'h0)
      begin
         got.push_back({abBit9, efBus, cdBus, fallHalf});
      end
   end
endmodule

`default_nettype wire

// >>> dv/rddp_rx_ddr_out_tb.sv
// rddp_rx_ddr_out_tb: self-checking bench for the receive ddr output.
// assumes mode pins are only changed while reset is held.
`timescale 1ns/1ps
`default_nettype none

module rddp_rx_ddr_out_tb;
   import rddp_pkg::*;

   logic clock, resetn, referenceClock, recoveredClock;
   logic inValid, inReady, nibbleMode, decodeSelect, clockToleranceComp;
   logic rxByteClock, cdBit8, cdBit9, efBit8, efBit9, abBit9;
   logic [RDDP_BYTE_W-1:0] cdLow, efLow;
   rddp_word_s inWord;
   int n_errors = 0;
   int checks = 0;

   // ----------------------------------------------------------------
   // clocks and instances
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // link clock offset so none of its edges meets a core clock edge
   initial
   begin
      referenceClock = 1'b0;
      #7;
      forever #15 referenceClock = ~referenceClock;
   end
   initial
   begin
      recoveredClock = 1'b0;
      #1;
      forever #3 recoveredClock = ~recoveredClock;
   end
   initial
   begin
      resetn = 1'b0; inValid = 1'b0; inWord = '0;
      nibbleMode = 1'b0; decodeSelect = 1'b0; clockToleranceComp = 1'b1;
   end

   rddp_rx_ddr_out dut (.clock(clock), .resetn(resetn), .inWord(inWord),
      .inValid(inValid), .inReady(inReady), .referenceClock(referenceClock),
      .recoveredClock(recoveredClock), .nibbleMode(nibbleMode),
      .decodeSelect(decodeSelect), .clockToleranceComp(clockToleranceComp),
      .rxByteClock(rxByteClock), .rxPairCdBusLow(cdLow),
      .rxPairCdBit8Kflag(cdBit8), .rxPairCdBit9(cdBit9),
      .rxPairEfBusLow(efLow), .rxPairEfBit8Kflag(efBit8),
      .rxPairEfBit9(efBit9), .rxPairAbBit9(abBit9));

   rddp_proto_model pm (.rxByteClock(rxByteClock),
      .cdBus({cdBit9, cdBit8, cdLow}), .efBus({efBit9, efBit8, efLow}),
      .abBit9(abBit9));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [41:0] e,
                      input logic [41:0] s);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask

   function automatic rddp_word_s mk(input int i);
      rddp_word_s w;
      for (int p = 0; p < RDDP_PAIRS; p++)
      begin
         w.pair[p].first.data = 10'h2a5 ^ 10'(i * 37 + p * 11);
         w.pair[p].first.kFlag = 1'((i + p) % 2);
         w.pair[p].second.data = ~w.pair[p].first.data;
         w.pair[p].second.kFlag = ~w.pair[p].first.kFlag;
      end
      return w;
   endfunction

   // one bus slot as the far end should see it
   function automatic rddp_bus_t slot(input rddp_pair_s p, input logic nib,
                                      input logic dec, input logic rise);
      rddp_chan_s c;
      logic [9:0] f, s;
      c = rise ? p.second : p.first;
      f = p.first.data;
      s = p.second.data;
      if (!nib)
         return dec ? {1'b0, c.kFlag, c.data[7:0]} : c.data;
      if (!dec)
         return rise ? {s[9:5], f[9:5]} : {s[4:0], f[4:0]};
      return rise ? {s[7], p.second.kFlag, s[6:4], f[7], p.first.kFlag, f[6:4]}
                  : {1'b0, s[3:0], 1'b0, f[3:0]};
   endfunction

   function automatic logic [41:0] expect_word(input rddp_word_s w,
      input logic nib, input logic dec);
      logic [20:0] h[2];
      rddp_bus_t ab;
      for (int r = 0; r < 2; r++)
      begin
         // only bit 9 of pair ab leaves the block
         ab = slot(w.pair[RDDP_PAIR_AB], nib, dec, 1'(r));
         h[r] = {ab[RDDP_BIT9],
                 slot(w.pair[RDDP_PAIR_EF], nib, dec, 1'(r)),
                 slot(w.pair[RDDP_PAIR_CD], nib, dec, 1'(r))};
      end
      return {h[1], h[0]};
   endfunction

   // caller stands at a rising clock edge; returns at the taking edge
   task automatic send(input rddp_word_s w);
      logic rdy;
      inWord <= w;
      inValid <= 1'b1;
      for (int k = 0; k < 200; k++)
      begin
         @(negedge clock);
         rdy = inReady;
         @(posedge clock);
         if (rdy === 1'b1)
            return;
      end
      n_errors++;
      results();
   endtask

   // ----------------------------------------------------------------
   // one scenario per mux and nibble mode on the reference clock, plus nibble raw on the divided clock
   // ----------------------------------------------------------------
   task automatic run(input logic nib, input logic dec, input logic comp);
      int k;
      logic [3:0] edges;
      resetn <= 1'b0;
      nibbleMode <= nib;
      decodeSelect <= dec;
      clockToleranceComp <= comp;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge rxByteClock);
      pm.got.delete();
      cmp("ready idle", 42'h1, 42'(inReady));
      @(posedge clock);
      // four words back to back fill the two-entry buffer and stall on inReady
      for (int i = 0; i < 4; i++)
         send(mk(i));
      inValid <= 1'b0;
      k = 0;
      while (pm.got.size() < 4 && k < 4000)
      begin
         @(posedge clock);
         k++;
      end
      if (k >= 4000)
      begin
         n_errors++;
         results();
      end
      for (int i = 0; i < 4; i++)
         cmp("word", expect_word(mk(i), nib, dec), pm.got[i]);
      repeat (6) @(posedge rxByteClock);
      cmp("words seen", 42'(4), 42'(pm.got.size()));
      #2;
      cmp("idle bus", 42'h0,
          {abBit9, cdBit9, cdBit8, cdLow, efBit9, efBit8, efLow});
      if (comp)
      begin
         repeat (4)
         begin
            @(posedge referenceClock);
            #2;
            cmp("byte clock", 42'(referenceClock), 42'(rxByteClock));
         end
      end
      else
      begin
         @(posedge rxByteClock);
         edges = 4'h0;
         fork
            forever @(posedge recoveredClock) edges++;
            @(posedge rxByteClock);
         join_any
         disable fork;
         cmp("divide ratio", 42'(RDDP_DIV_RATIO), 42'(edges));
      end
      $display("mode nib %0b dec %0b comp %0b done", nib, dec, comp);
   endtask

   initial
   begin
      #500us;
      n_errors++;
      results();
   end

   initial
   begin
      run(1'b0, 1'b0, 1'b1);
      run(1'b0, 1'b1, 1'b1);
      run(1'b1, 1'b0, 1'b1);
      run(1'b1, 1'b1, 1'b1);
      run(1'b1, 1'b0, 1'b0);
      results();
   end
endmodule

`default_nettype wire
